/* pkg/ecgf_pkg.sv */
// Shared constants, types and decoding for the ECG lead and electrode formatter.
// Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
`default_nettype none
package ecgf_pkg;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0] CHAN_CTRL_IDX  = 8'h01;
   localparam logic [7:0] CM_REF_IDX     = 8'h05;
   localparam logic [7:0] FRAME_CTRL_IDX = 8'h0a;
   localparam logic [7:0] STATUS_IDX     = 8'h0b;
   localparam logic [7:0] FRAME_CNT_IDX  = 8'h0c;
   localparam logic [7:0] WORD_BASE_IDX  = 8'h10;

   // Field positions.
   localparam int FMT_BIT        = 4;
   localparam int RATE_LSB       = 0;
   localparam int TOPO_BIT       = 10;
   localparam int SHARED_EN_BIT  = 8;
   localparam int ST_MODE_LSB    = 0;
   localparam int ST_BADMODE_BIT = 4;
   localparam int ST_RATE_BIT    = 5;
   localparam int ST_OVERRUN_BIT = 6;
   localparam int ST_BUSY_BIT    = 8;

   // Frame data rate codes held in the frame control register.
   localparam logic [1:0] RATE_2K   = 2'h0;
   localparam logic [1:0] RATE_16K  = 2'h1;
   localparam logic [1:0] RATE_128K = 2'h2;

   // Reset values.
   localparam logic [31:0] FRAME_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CHAN_CTRL_RST  = 32'h0000_0400;
   localparam logic [31:0] CM_REF_RST     = 32'h0000_0000;

   typedef enum logic [2:0] {
      MODE_ANALOG  = 3'h0,
      MODE_DIGITAL = 3'h1,
      MODE_CE_A    = 3'h2,
      MODE_SINGLE  = 3'h3,
      MODE_CE_B    = 3'h4,
      MODE_BAD     = 3'h7
   } ecgf_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ALIGN = 2'b01,
      ST_FORM  = 2'b11
   } ecgf_state_t;

   function automatic ecgf_mode_t ecgf_decode(input logic fmt, input logic topo,
                                              input logic ce);
      case ({fmt, topo, ce})
         3'b010:  ecgf_decode = MODE_ANALOG;
         3'b000:  ecgf_decode = MODE_DIGITAL;
         3'b001:  ecgf_decode = MODE_CE_A;
         3'b100:  ecgf_decode = MODE_SINGLE;
         3'b101:  ecgf_decode = MODE_CE_B;
         default: ecgf_decode = MODE_BAD;
      endcase
   endfunction

endpackage
`default_nettype wire

/* rtl/ecgf_div3.sv */
// Signed division by three, truncating toward zero.
// Assumes a registered operand; the result is combinational.
`timescale 1ns/1ps
`default_nettype none
module ecgf_div3 #(
   parameter int VAL_W = 17
) (
   input  wire logic signed [VAL_W-1:0] val_i,
   output logic signed [VAL_W-1:0]      third_o
);

   localparam logic signed [VAL_W-1:0] DIVISOR = VAL_W'(3);

   if (VAL_W < 3)
      $error("Operand too narrow for division by three.");

   assign third_o = val_i / DIVISOR;

endmodule
`default_nettype wire

/* rtl/ecgf_formatter.sv */
// ECG lead and electrode formatter: five output words per frame in one of five modes.
// Assumes five channel samples with a one-cycle valid strobe and a classic Wishbone master.
`timescale 1ns/1ps
`default_nettype none

module ecgf_formatter
   import ecgf_pkg::*;
#(
   parameter int SAMPLE_W = 14,
   parameter int REF_CODE = 8192
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [11:0]           wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   input  wire logic                  sample_valid_i,
   input  wire logic [SAMPLE_W-1:0]   ch1_i,
   input  wire logic [SAMPLE_W-1:0]   ch2_i,
   input  wire logic [SAMPLE_W-1:0]   ch3_i,
   input  wire logic [SAMPLE_W-1:0]   ch4_i,
   input  wire logic [SAMPLE_W-1:0]   ch5_i,
   output logic signed [SAMPLE_W+2:0] word1_o,
   output logic signed [SAMPLE_W+2:0] word2_o,
   output logic signed [SAMPLE_W+2:0] word3_o,
   output logic signed [SAMPLE_W+2:0] word4_o,
   output logic signed [SAMPLE_W+2:0] word5_o,
   output logic                       frame_valid_o
);

   localparam int SW = SAMPLE_W + 1;
   localparam int OW = SAMPLE_W + 3;
   localparam int NCH = 5;

   if (SAMPLE_W < 4 || SAMPLE_W > 28)
      $error("Sample width must lie between 4 and 28 bits.");
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
            r[8*b +: 8] = new_v[8*b +: 8];
      end
      return r;
   endfunction
   function automatic logic [31:0] word_bits(input logic signed [OW-1:0] w);
      return 32'($signed(w));
   endfunction

   // Register storage.
   logic [31:0]        frame_control_reg;
   logic [31:0]        channel_control_reg;
   logic [31:0]        common_mode_ref_reg;
   logic [31:0]        frame_cnt_reg;
   logic               bad_mode_reg;
   logic               rate_refused_reg;
   logic               overrun_reg;
   logic               ack_reg;
   logic [31:0]        rd_reg;
   logic [31:0]        rd_next;
   logic               output_format_sel;
   logic               input_topology_sel;
   logic               shared_electrode_enable;
   logic [1:0]         rate_sel;
   ecgf_mode_t         live_mode;
   assign output_format_sel       = frame_control_reg[FMT_BIT];
   assign input_topology_sel      = channel_control_reg[TOPO_BIT];
   assign shared_electrode_enable = common_mode_ref_reg[SHARED_EN_BIT];
   assign rate_sel                = frame_control_reg[RATE_LSB +: 2];
   assign live_mode = ecgf_decode(output_format_sel, input_topology_sel,
                                  shared_electrode_enable);

   // Bus decode.
   logic               req;
   logic               wr_go;
   logic [7:0]         idx;
   logic               in_page;
   assign req     = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr_go   = req & wb_we_i;
   assign idx     = wb_adr_i[9:2];
   assign in_page = (wb_adr_i[11:10] == 2'h0);

   // Datapath state.
   ecgf_state_t               state_reg;
   ecgf_mode_t                mode_reg;
   logic signed [SW-1:0]      strip_w [NCH];
   logic signed [SW-1:0]      el_reg  [NCH];
   logic signed [SW+1:0]      sum_reg;
   logic signed [SW+1:0]      third_w;
   logic signed [OW-1:0]      w_reg   [NCH];
   logic                      valid_reg;
   logic [SAMPLE_W-1:0]       raw_w   [NCH];
   logic                      take;
   logic                      rate_ok;
   logic                      refuse_rate;
   logic                      refuse_mode;

   assign raw_w = '{ch1_i, ch2_i, ch3_i, ch4_i, ch5_i};

   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_strip
         ecgf_ref_strip #(
            .SAMPLE_W (SAMPLE_W),
            .REF_CODE (REF_CODE)
         ) u_strip (
            .raw_i   (raw_w[g]),
            .level_o (strip_w[g])
         );
      end
   endgenerate

   ecgf_div3 #(
      .VAL_W (SW + 2)
   ) u_div3 (
      .val_i   (sum_reg),
      .third_o (third_w)
   );

   assign take        = sample_valid_i & (state_reg == ST_IDLE);
   assign rate_ok     = (rate_sel == RATE_2K) | (rate_sel == RATE_16K);
   assign refuse_rate = (live_mode == MODE_DIGITAL) & ~rate_ok;
   assign refuse_mode = (live_mode == MODE_BAD);
   // Wishbone acknowledge: one cycle after the request, dropped the cycle after.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_reg <= 1'b0;
      else
         ack_reg <= req;
   end

   always_comb
   begin
      rd_next = 32'h0;
      if (in_page)
      begin
         case (idx)
            FRAME_CTRL_IDX: rd_next = frame_control_reg;
            CHAN_CTRL_IDX:  rd_next = channel_control_reg;
            CM_REF_IDX:     rd_next = common_mode_ref_reg;
            STATUS_IDX:
            begin
               rd_next[ST_MODE_LSB +: 3] = live_mode;
               rd_next[ST_BADMODE_BIT]   = bad_mode_reg;
               rd_next[ST_RATE_BIT]      = rate_refused_reg;
               rd_next[ST_OVERRUN_BIT]   = overrun_reg;
               rd_next[ST_BUSY_BIT]      = (state_reg != ST_IDLE);
            end
            FRAME_CNT_IDX:     rd_next = frame_cnt_reg;
            WORD_BASE_IDX:     rd_next = word_bits(w_reg[0]);
            WORD_BASE_IDX + 8'h1: rd_next = word_bits(w_reg[1]);
            WORD_BASE_IDX + 8'h2: rd_next = word_bits(w_reg[2]);
            WORD_BASE_IDX + 8'h3: rd_next = word_bits(w_reg[3]);
            WORD_BASE_IDX + 8'h4: rd_next = word_bits(w_reg[4]);
            default:           rd_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rd_reg <= 32'h0;
      else if (req & ~wb_we_i)
         rd_reg <= rd_next;
   end

   // Configuration registers; a write takes effect at the acknowledging edge.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         frame_control_reg   <= FRAME_CTRL_RST;
         channel_control_reg <= CHAN_CTRL_RST;
         common_mode_ref_reg <= CM_REF_RST;
      end
      else if (wr_go & in_page)
      begin
         case (idx)
            FRAME_CTRL_IDX:
               frame_control_reg <= merge_bytes(frame_control_reg, wb_dat_i, wb_sel_i);
            CHAN_CTRL_IDX:
               channel_control_reg <= merge_bytes(channel_control_reg, wb_dat_i, wb_sel_i);
            CM_REF_IDX:
               common_mode_ref_reg <= merge_bytes(common_mode_ref_reg, wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
   end

   // Sticky status flags, cleared by writing one; a new event wins over the clear.
   logic clr_hit;
   logic [31:0] clr_bits;
   assign clr_hit  = wr_go & in_page & (idx == STATUS_IDX);
   assign clr_bits = clr_hit ? merge_bytes(32'h0, wb_dat_i, wb_sel_i) : 32'h0;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bad_mode_reg     <= 1'b0;
         rate_refused_reg <= 1'b0;
         overrun_reg      <= 1'b0;
      end
      else
      begin
         bad_mode_reg <= (bad_mode_reg & ~clr_bits[ST_BADMODE_BIT])
                         | (take & refuse_mode);
         rate_refused_reg <= (rate_refused_reg & ~clr_bits[ST_RATE_BIT])
                             | (take & refuse_rate);
         overrun_reg <= (overrun_reg & ~clr_bits[ST_OVERRUN_BIT])
                        | (sample_valid_i & (state_reg != ST_IDLE));
      end
   end
   // Frame sequencer: capture, align, form.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= ST_IDLE;
         mode_reg  <= MODE_ANALOG;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               if (take & ~refuse_rate & ~refuse_mode)
               begin
                  state_reg <= ST_ALIGN;
                  mode_reg  <= live_mode;
               end
            end
            ST_ALIGN: state_reg <= ST_FORM;
            ST_FORM:  state_reg <= ST_IDLE;
            default:  state_reg <= ST_IDLE;
         endcase
      end
   end

   // Capture samples with the reference level already removed.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         for (int i = 0; i < NCH; i++)
            el_reg[i] <= '0;
      else if (take)
         for (int i = 0; i < NCH; i++)
            el_reg[i] <= strip_w[i];
   end
   // Sum feeding the one-third term.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sum_reg <= '0;
      else if (state_reg == ST_ALIGN)
      begin
         if (mode_reg == MODE_DIGITAL)
            sum_reg <= (SW+2)'(el_reg[0]) + (SW+2)'(el_reg[1])
                       + (SW+2)'(el_reg[2]);
         else
            sum_reg <= (SW+2)'(el_reg[0]) + (SW+2)'(el_reg[1]);
      end
   end
   // Word formation per mode.
   logic signed [OW-1:0] e [NCH];
   logic signed [OW-1:0] central_terminal_avg;
   logic signed [OW-1:0] f [NCH];
   always_comb
   begin
      for (int i = 0; i < NCH; i++)
         e[i] = OW'(el_reg[i]);
      central_terminal_avg = OW'(third_w);
      for (int i = 0; i < NCH; i++)
         f[i] = e[i];
      case (mode_reg)
         MODE_ANALOG: f[1] = -e[1];
         MODE_DIGITAL:
         begin
            // Uses the computed terminal; the common-mode register plays no part.
            f[0] = e[0] - e[2];
            f[1] = e[1] - e[2];
            f[2] = e[1] - e[0];
            f[3] = e[3] - central_terminal_avg;
            f[4] = e[4] - central_terminal_avg;
         end
         MODE_CE_A:
         begin
            f[2] = e[2] - central_terminal_avg;
            f[3] = e[3] - central_terminal_avg;
            f[4] = e[4] - central_terminal_avg;
         end
         MODE_SINGLE: f[0] = e[0];
         MODE_CE_B:
         begin
            f[2] = e[3];
            f[3] = e[4];
            f[4] = e[2];
         end
         default: f[0] = e[0];
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < NCH; i++)
            w_reg[i] <= '0;
         valid_reg <= 1'b0;
      end
      else
      begin
         valid_reg <= (state_reg == ST_FORM);
         if (state_reg == ST_FORM)
            for (int i = 0; i < NCH; i++)
               w_reg[i] <= f[i];
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         frame_cnt_reg <= 32'h0;
      else if (state_reg == ST_FORM)
         frame_cnt_reg <= frame_cnt_reg + 32'h1;
   end
   assign wb_ack_o      = ack_reg;
   assign wb_dat_o      = rd_reg;
   assign word1_o       = w_reg[0];
   assign word2_o       = w_reg[1];
   assign word3_o       = w_reg[2];
   assign word4_o       = w_reg[3];
   assign word5_o       = w_reg[4];
   assign frame_valid_o = valid_reg;

endmodule
`default_nettype wire

/* rtl/ecgf_ref_strip.sv */
// Removes the internal reference level from one offset-binary ADC sample.
// Assumes the sample comes from converter logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ecgf_ref_strip #(
   parameter int SAMPLE_W = 14,
   parameter int REF_CODE = 8192
) (
   input  wire logic [SAMPLE_W-1:0] raw_i,
   output logic signed [SAMPLE_W:0] level_o
);

   localparam logic signed [SAMPLE_W:0] REF_LVL = (SAMPLE_W+1)'(REF_CODE);

   if (REF_CODE < 0 || REF_CODE >= (1 << SAMPLE_W))
      $error("Reference code outside the sample range.");

   assign level_o = $signed({1'b0, raw_i}) - REF_LVL;

endmodule
`default_nettype wire

/* test/ecgf_formatter_monitor.sv */
// Port-level checker for the ECG formatter: bus handshake and frame timing.
// Assumes it is bound to every ecgf_formatter instance and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ecgf_formatter_monitor
   import ecgf_pkg::*;
#(
   parameter int SAMPLE_W = 14,
   parameter int REF_CODE = 8192
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [11:0]           wb_adr_i,
   input  wire logic [31:0]           wb_dat_o,
   input  wire logic                  wb_ack_o,
   input  wire logic                  sample_valid_i,
   input  wire logic signed [SAMPLE_W+2:0] word1_o,
   input  wire logic signed [SAMPLE_W+2:0] word5_o,
   input  wire logic                  frame_valid_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   chk_ack_one_cycle: assert property (s_req |=> s_ack_pulse)
      else $error("bus ack not one pulse one cycle after request");
   chk_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("bus ack without request");
   chk_frame_spacing: assert property (frame_valid_o |=> !frame_valid_o [*2])
      else $error("frame valid pulses too close");
   chk_frame_latency: assert property (frame_valid_o |-> $past(sample_valid_i, 3))
      else $error("frame valid not three cycles after sample");
   chk_words_hold: assert property (($changed(word1_o) || $changed(word5_o)) |-> frame_valid_o)
      else $error("output words changed outside a frame");
   chk_reset_clean: assert property ($fell(rst_i) |-> !wb_ack_o && !frame_valid_o
                                     && wb_dat_o == 32'h0 && word1_o == '0)
      else $error("outputs not cleared by reset");
   chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[11:10] != 2'b00
                                       |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_word_readback: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 12'h040
                                       |-> wb_dat_o == 32'(word1_o))
      else $error("first word register differs from port");
endmodule
bind ecgf_formatter ecgf_formatter_monitor #(.SAMPLE_W(SAMPLE_W), .REF_CODE(REF_CODE)) u_mon (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .sample_valid_i(sample_valid_i), .word1_o(word1_o), .word5_o(word5_o),
   .frame_valid_o(frame_valid_o));
`default_nettype wire

/* test/ecgf_sample_src.sv */
// Converter-side model that presents one frame of five offset-binary samples.
// Assumes the bench calls send after a clock edge; channels hold only while valid.
`timescale 1ns/1ps
`default_nettype none
module ecgf_sample_src #(
   parameter int W = 14
) (
   input  wire logic         clk_i,
   output logic              valid_o,
   output logic [W-1:0]      ch_o [5]
);
   initial
   begin
      valid_o = 1'b0;
      ch_o = '{default: '0};
   end

   // Outside a frame the channels carry the inverse of the last sample so stale data shows.
   task automatic send(input logic [W-1:0] s [5], input int gap, input int hold);
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      valid_o <= 1'b1;
      for (int i = 0; i < 5; i++)
         ch_o[i] <= s[i];
      repeat (hold) @(posedge clk_i);
      valid_o <= 1'b0;
      for (int i = 0; i < 5; i++)
         ch_o[i] <= ~s[i];
   endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the ECG formatter: registers, five modes, refusals.
// Assumes the package constants and a sample source model in the same run.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ecgf_pkg::*;
   localparam int REF = 8192;
   logic              clk_i, rst_i, cyc, stb, wwe, frame_valid_o, wb_ack_o, svalid;
   logic [11:0]       adr;
   logic [3:0]        sel;
   logic [31:0]       dat, wb_dat_o, q;
   logic [13:0]       sch [5];
   logic [13:0]       smp [5];
   logic signed [16:0] w [5];
   logic [1:0]        rate;
   int                seed = 32'hb2d326cf;
   int                error_cnt = 0;
   int                tests_run = 0;
   ecgf_mode_t        mtab [5] = '{MODE_ANALOG, MODE_DIGITAL, MODE_CE_A, MODE_SINGLE, MODE_CE_B};
   logic [2:0]        btab [5] = '{3'b010, 3'b000, 3'b001, 3'b100, 3'b101};

   ecgf_formatter #(.SAMPLE_W(14), .REF_CODE(REF)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .sample_valid_i(svalid), .ch1_i(sch[0]), .ch2_i(sch[1]), .ch3_i(sch[2]), .ch4_i(sch[3]),
      .ch5_i(sch[4]), .word1_o(w[0]), .word2_o(w[1]), .word3_o(w[2]), .word4_o(w[3]),
      .word5_o(w[4]), .frame_valid_o(frame_valid_o));
   ecgf_sample_src #(.W(14)) src (.clk_i(clk_i), .valid_o(svalid), .ch_o(sch));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      wwe <= we;
      adr <= a;
      dat <= d;
      sel <= s;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      chk("bus_ack_delay", 32'(n), 32'd2);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic setm(input logic [2:0] b, input logic [1:0] rt, input logic [7:0] junk);
      logic [31:0] r;
      wb(1'b1, 12'h028, {27'h0, b[2], 2'h0, rt}, 4'hf, r);
      wb(1'b1, 12'h004, {21'h0, b[1], 10'h0}, 4'hf, r);
      wb(1'b1, 12'h014, {23'h0, b[0], junk}, 4'hf, r);
   endtask

   function automatic int expw(input ecgf_mode_t m, input int k);
      int l [5];
      for (int i = 0; i < 5; i++)
         l[i] = int'(smp[i]) - REF;
      case (m)
         MODE_ANALOG:
            return (k == 1) ? -l[1] : l[k];
         MODE_DIGITAL:
         begin
            if (k == 0)
               return l[0] - l[2];
            if (k == 1)
               return l[1] - l[2];
            if (k == 2)
               return l[1] - l[0];
            return l[k] - (l[0] + l[1] + l[2]) / 3;
         end
         MODE_CE_A:
            return (k < 2) ? l[k] : l[k] - (l[0] + l[1]) / 3;
         MODE_CE_B:
            return (k < 2) ? l[k] : (k == 4) ? l[2] : l[k + 1];
         default:
            return l[k];
      endcase
   endfunction

   task automatic frame(input int m, input bit ok);
      bit got;
      got = 1'b0;
      for (int i = 0; i < 8 && !got; i++)
      begin
         @(negedge clk_i);
         got = (frame_valid_o === 1'b1);
      end
      chk("frame_valid", {31'h0, got}, {31'h0, ok});
      if (got)
         for (int k = 0; k < 5; k++)
            chk("word", 32'(w[k]), 32'(expw(mtab[m], k)));
      if (got && mtab[m] == MODE_CE_A)
         chk("ce_lead3", 32'(w[1] - w[0]), 32'(expw(MODE_DIGITAL, 2)));
   endtask

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Whole run is about 700 cycles; this limit of 40000 cycles is over fifty times that.
   initial
   begin
      #(25 * 40000);
      error_cnt++;
      stop_test();
   end

   initial
   begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      wwe = 1'b0;
      adr = 12'h0;
      sel = 4'h0;
      dat = 32'h0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 12'h004, 32'h0, 4'hf, q);
      chk("chan_ctrl", q, CHAN_CTRL_RST);
      wb(1'b0, 12'h028, 32'h0, 4'hf, q);
      chk("frame_ctrl", q, FRAME_CTRL_RST);
      wb(1'b0, 12'h014, 32'h0, 4'hf, q);
      chk("cm_ref", q, CM_REF_RST);
      wb(1'b0, 12'h02c, 32'h0, 4'hf, q);
      chk("status", q, 32'h0);
      wb(1'b1, 12'h030, 32'h5a5a5a5a, 4'hf, q);
      wb(1'b0, 12'h030, 32'h0, 4'hf, q);
      chk("frame_cnt_ro", q, 32'h0);
      wb(1'b1, 12'h800, 32'hffffffff, 4'hf, q);
      wb(1'b0, 12'h800, 32'h0, 4'hf, q);
      chk("unmapped", q, 32'h0);
      $display("reset and map test done");
      for (int m = 0; m < 5; m++)
      begin
         for (int n = 0; n < 6; n++)
         begin
            for (int i = 0; i < 5; i++)
               smp[i] = (n == 0) ? 14'h0 : (n == 1) ? 14'h3fff : 14'($random(seed));
            rate = (m == 1) ? {1'b0, 1'($random(seed))} : 2'(n % 3);
            setm(btab[m], rate, 8'($random(seed)));
            src.send(smp, n % 4, 1);
            frame(m, 1'b1);
            if (n == 2)
               for (int k = 0; k < 5; k++)
               begin
                  wb(1'b0, 12'h040 + 12'(4 * k), 32'h0, 4'hf, q);
                  chk("word_reg", q, 32'(expw(mtab[m], k)));
               end
         end
         wb(1'b0, 12'h02c, 32'h0, 4'hf, q);
         chk("live_mode", {29'h0, q[2:0]}, {29'h0, mtab[m]});
         $display("mode %0d test done", m);
      end
      for (int i = 0; i < 5; i++)
         smp[i] = 14'($random(seed));
      for (int r = 2; r < 4; r++)
      begin
         setm(3'b000, 2'(r), 8'h0);
         src.send(smp, 0, 1);
         frame(1, 1'b0);
         wb(1'b0, 12'h02c, 32'h0, 4'hf, q);
         chk("rate_flag", {31'h0, q[5]}, 32'h1);
         wb(1'b1, 12'h02c, 32'h70, 4'h1, q);
      end
      setm(3'b110, 2'h0, 8'h0);
      src.send(smp, 0, 1);
      frame(0, 1'b0);
      wb(1'b0, 12'h02c, 32'h0, 4'hf, q);
      chk("bad_mode", {28'h0, q[4], q[2:0]}, 32'hf);
      wb(1'b1, 12'h02c, 32'h70, 4'h1, q);
      setm(3'b100, 2'h0, 8'h0);
      src.send(smp, 0, 2);
      frame(3, 1'b1);
      wb(1'b0, 12'h02c, 32'h0, 4'hf, q);
      chk("overrun", {31'h0, q[6]}, 32'h1);
      wb(1'b0, 12'h030, 32'h0, 4'hf, q);
      chk("frame_cnt", q, 32'd31);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 12'h02c, 32'h0, 4'hf, q);
      chk("status_after_rst", q, 32'h0);
      chk("word_after_rst", 32'(w[0]), 32'h0);
      wb(1'b0, 12'h030, 32'h0, 4'hf, q);
      chk("cnt_after_rst", q, 32'h0);
      $display("refusal test done");
      stop_test();
   end
endmodule
`default_nettype wire
